// file: hw/lbte_pkg.sv
package lbte_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // register byte addresses
  localparam int unsigned ADDR_W = 24;
  localparam logic [23:0] EVENT_BUS_OFF  = 24'hF06000;
  localparam logic [23:0] DIAG_CTRL_OFF  = 24'hF06010;
  localparam logic [23:0] ASSIGN_A_OFF   = 24'hF06014;
  localparam logic [23:0] ASSIGN_B_OFF   = 24'hF06018;
  localparam logic [23:0] INT_SOURCE_OFF = 24'hF0601C;
  localparam logic [23:0] INT_DATA_OFF   = 24'hF06020;
  localparam logic [23:0] BUF_PTR_OFF    = 24'hF06024;
  localparam logic [23:0] BUF_A_DATA_OFF = 24'hF06028;
  localparam logic [23:0] BUF_B_DATA_OFF = 24'hF0602C;

  ////////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int unsigned DIAG_XFER_BIT    = 2;
  localparam int unsigned ASSIGN_BIT       = 5;
  localparam int unsigned ASSIGN_WRITE_BIT = 4;
  localparam int unsigned INT_NOMOD_BIT    = 4;
  localparam int unsigned INT_TC_A_BIT     = 5;
  localparam int unsigned INT_TC_B_BIT     = 6;

  ////////////////////////////////////////////////////////////////////////////////
  // reset values and sizes
  localparam logic [5:0] EVENT_RST  = 6'h3E;
  localparam logic [7:0] DIAG_RST   = 8'h00;
  localparam logic [7:0] ASSIGN_RST = 8'h00;
  localparam int unsigned BUF_DEPTH = 4096;
  localparam int unsigned DATA_W    = 16;

  typedef enum logic [3:0] {
    REG_NONE, REG_EVENT, REG_DIAG, REG_ASG_A, REG_ASG_B,
    REG_INT_SRC, REG_INT_DATA, REG_PTR, REG_BUF_A, REG_BUF_B
  } lbte_reg_e;

  typedef enum logic [1:0] {XF_IDLE, XF_RD, XF_WR} lbte_xfer_e;

endpackage : lbte_pkg

// file: hw/lbte_buf_ram.sv
`timescale 1ns/100ps
`default_nettype none

// both buffers share one address; one is read while the other is written
module lbte_buf_ram #(
  parameter int unsigned DEPTH = 4096,
  parameter int unsigned DW    = 16,
  parameter int unsigned AW    = 12
) (
  // clock
  input  wire logic          clk,
  // access
  input  wire logic [AW-1:0] addr,
  input  wire logic          we_a,
  input  wire logic          we_b,
  input  wire logic [DW-1:0] wdata,
  output logic      [DW-1:0] rdata_a,
  output logic      [DW-1:0] rdata_b
);

  logic [DW-1:0] mem_a [DEPTH];
  logic [DW-1:0] mem_b [DEPTH];

  always_ff @(posedge clk) begin
    if (we_a) begin
      mem_a[addr] <= wdata;
    end
    if (we_b) begin
      mem_b[addr] <= wdata;
    end
    rdata_a <= mem_a[addr];
    rdata_b <= mem_b[addr];
  end

endmodule : lbte_buf_ram

`default_nettype wire

// file: hw/lbte_link_buffer.sv
// Our own choice: register access over APB.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// [R1] Setting the transfer bit copies one buffer RAM into the other, direction from assignments.
// [R2] The transfer bit is bit two of the diagnostic control register; writing one launches it.
// [R3] Finishing a copy asserts the link interrupt line.
// [R4] After a copy every destination word equals the source word from pointer zero upward.
// [R5] Finishing a copy clears bit 5 of both buffer assignment registers.
// [R6] Terminal count of buffers A and B sets bits 5 and 6 of the interrupt source register.
// [R7] Reading the interrupt source register clears its bits 5 and 6.
// [R8] Reading the interrupt data register drops the module interrupt and sets source bit 4.
// [R9] The interrupt line stays high while any source is pending and falls when all are cleared.
// [R10] The event register drives trigger active high on bit 0 and five sources active low.
// [R11] Reading the event register returns the six line states with weights 1 to 20 hex.
// [R12] All lines but the trigger read back inverted against their driven source value.
module lbte_link_buffer #(
  parameter int unsigned DEPTH = lbte_pkg::BUF_DEPTH
) (
  // clock and reset
  input  wire logic                        mclk,
  input  wire logic                        rst,
  // apb slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [lbte_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic                             pready,
  output logic      [31:0]                 prdata,
  output logic                             pslverr,
  // module interrupt from the link side
  input  wire logic                        module_irq_valid,
  input  wire logic [15:0]                 module_irq_data,
  output logic                             link_interrupt_line,
  // event bus drive
  output logic                             external_trigger_source,
  output logic                             run_halt_source,
  output logic                             event_source_one,
  output logic                             event_source_two,
  output logic                             event_source_three,
  output logic                             event_source_four,
  // event bus line states
  input  wire logic                        trigger_line,
  input  wire logic                        run_halt_event_line,
  input  wire logic                        event_line_one,
  input  wire logic                        event_line_two,
  input  wire logic                        event_line_three,
  input  wire logic                        event_line_four
);

  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  typedef struct packed {
    logic [5:0]           ev;
    logic [7:0]           diag;
    logic [7:0]           asg_a;
    logic [7:0]           asg_b;
    logic                 tc_a;
    logic                 tc_b;
    logic                 mod_pend;
    logic [15:0]          mod_data;
    logic [AW-1:0]        ptr;
    lbte_pkg::lbte_xfer_e xf;
    logic [AW-1:0]        idx;
    logic                 a2b;
    logic                 settle;
    logic                 irq;
    logic                 pready;
    logic                 pslverr;
    logic [31:0]          prdata;
  } lbte_state_s;

  localparam lbte_state_s ST_RST = '{
    ev: lbte_pkg::EVENT_RST, diag: lbte_pkg::DIAG_RST, asg_a: lbte_pkg::ASSIGN_RST,
    asg_b: lbte_pkg::ASSIGN_RST, tc_a: 1'b0, tc_b: 1'b0, mod_pend: 1'b0,
    mod_data: 16'h0000, ptr: '0, xf: lbte_pkg::XF_IDLE, idx: '0, a2b: 1'b0,
    irq: 1'b0, settle: 1'b0, pready: 1'b0, pslverr: 1'b0, prdata: 32'h00000000};

  function automatic lbte_pkg::lbte_reg_e lbte_decode(input logic [lbte_pkg::ADDR_W-1:0] a);
    unique case (a)
      lbte_pkg::EVENT_BUS_OFF:  return lbte_pkg::REG_EVENT;
      lbte_pkg::DIAG_CTRL_OFF:  return lbte_pkg::REG_DIAG;
      lbte_pkg::ASSIGN_A_OFF:   return lbte_pkg::REG_ASG_A;
      lbte_pkg::ASSIGN_B_OFF:   return lbte_pkg::REG_ASG_B;
      lbte_pkg::INT_SOURCE_OFF: return lbte_pkg::REG_INT_SRC;
      lbte_pkg::INT_DATA_OFF:   return lbte_pkg::REG_INT_DATA;
      lbte_pkg::BUF_PTR_OFF:    return lbte_pkg::REG_PTR;
      lbte_pkg::BUF_A_DATA_OFF: return lbte_pkg::REG_BUF_A;
      lbte_pkg::BUF_B_DATA_OFF: return lbte_pkg::REG_BUF_B;
      default:                  return lbte_pkg::REG_NONE;
    endcase
  endfunction : lbte_decode

  lbte_state_s         s_r;
  lbte_state_s         s_nxt;
  lbte_pkg::lbte_reg_e sel;
  logic                busy;
  logic                acc;
  logic                done_acc;
  logic                finish;
  logic                buf_sel;
  logic [5:0]          lines;
  logic [AW-1:0]       ram_addr;
  logic                ram_we_a;
  logic                ram_we_b;
  logic [15:0]         ram_wdata;
  logic [15:0]         ram_rdata_a;
  logic [15:0]         ram_rdata_b;

  assign sel      = lbte_decode(paddr);
  assign busy     = (s_r.xf != lbte_pkg::XF_IDLE);
  assign acc      = psel && penable;
  assign done_acc = acc && s_r.pready;
  assign buf_sel  = (sel == lbte_pkg::REG_BUF_A) || (sel == lbte_pkg::REG_BUF_B);
  assign finish   = (s_r.xf == lbte_pkg::XF_WR) && (s_r.idx == LAST_IDX);
  // [R12] raw line states, the board inverts all but the trigger
  // [R11] line weights
  assign lines    = {event_line_four, event_line_three, event_line_two,
                     event_line_one, run_halt_event_line, trigger_line};

  ////////////////////////////////////////////////////////////////////////////////
  // buffer ram

  lbte_buf_ram #(
    .DEPTH (DEPTH),
    .DW    (lbte_pkg::DATA_W),
    .AW    (AW)
  ) u_ram (
    .clk     (mclk),
    .addr    (ram_addr),
    .we_a    (ram_we_a),
    .we_b    (ram_we_b),
    .wdata   (ram_wdata),
    .rdata_a (ram_rdata_a),
    .rdata_b (ram_rdata_b)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [31:0] rd;
    rd        = 32'h00000000;
    s_nxt     = s_r;
    ram_we_a  = 1'b0;
    ram_we_b  = 1'b0;
    ram_addr  = busy ? s_r.idx : s_r.ptr;
    ram_wdata = busy ? (s_r.a2b ? ram_rdata_a : ram_rdata_b) : pwdata[15:0];
    s_nxt.pready = 1'b0;

    unique case (sel)
      lbte_pkg::REG_EVENT:    rd[5:0]  = lines;
      lbte_pkg::REG_DIAG: begin
        rd[7:0] = s_r.diag;
        rd[lbte_pkg::DIAG_XFER_BIT] = busy;
      end
      lbte_pkg::REG_ASG_A:    rd[7:0]  = s_r.asg_a;
      lbte_pkg::REG_ASG_B:    rd[7:0]  = s_r.asg_b;
      lbte_pkg::REG_INT_SRC: begin
        rd[lbte_pkg::INT_NOMOD_BIT] = !s_r.mod_pend;
        rd[lbte_pkg::INT_TC_A_BIT]  = s_r.tc_a;
        rd[lbte_pkg::INT_TC_B_BIT]  = s_r.tc_b;
      end
      lbte_pkg::REG_INT_DATA: rd[15:0] = s_r.mod_data;
      lbte_pkg::REG_PTR:      rd[AW-1:0] = s_r.ptr;
      lbte_pkg::REG_BUF_A:    rd[15:0] = ram_rdata_a;
      lbte_pkg::REG_BUF_B:    rd[15:0] = ram_rdata_b;
      lbte_pkg::REG_NONE:     rd = 32'h00000000;
    endcase

    // buffer windows wait while the copy owns the ram address, and one cycle
    // more so the ram output shows the pointer again, not the last copy index
    s_nxt.settle = busy;
    if (acc && !s_r.pready && !((busy || s_r.settle) && buf_sel)) begin
      s_nxt.pready  = 1'b1;
      s_nxt.pslverr = (sel == lbte_pkg::REG_NONE);
      s_nxt.prdata  = rd;
    end

    if (done_acc && pwrite) begin
      unique case (sel)
        // [R10] event drive
        lbte_pkg::REG_EVENT: s_nxt.ev = pwdata[5:0];
        lbte_pkg::REG_DIAG: begin
          s_nxt.diag = pwdata[7:0];
          s_nxt.diag[lbte_pkg::DIAG_XFER_BIT] = 1'b0;
          // [R2] launch copy
          if (pwdata[lbte_pkg::DIAG_XFER_BIT] && !busy) begin
            s_nxt.xf  = lbte_pkg::XF_RD;
            s_nxt.idx = '0;
            // [R1] direction from assignments
            s_nxt.a2b = s_r.asg_b[lbte_pkg::ASSIGN_WRITE_BIT];
          end
        end
        lbte_pkg::REG_ASG_A: s_nxt.asg_a = pwdata[7:0];
        lbte_pkg::REG_ASG_B: s_nxt.asg_b = pwdata[7:0];
        lbte_pkg::REG_PTR:   s_nxt.ptr   = pwdata[AW-1:0];
        lbte_pkg::REG_BUF_A: ram_we_a = 1'b1;
        lbte_pkg::REG_BUF_B: ram_we_b = 1'b1;
        default: ;
      endcase
    end

    if (done_acc && !pwrite) begin
      // [R7] clear on read
      if (sel == lbte_pkg::REG_INT_SRC) begin
        s_nxt.tc_a = 1'b0;
        s_nxt.tc_b = 1'b0;
      end
      // [R8] drop module interrupt
      if (sel == lbte_pkg::REG_INT_DATA) begin
        s_nxt.mod_pend = 1'b0;
      end
    end

    if (done_acc && buf_sel) begin
      s_nxt.ptr = s_r.ptr + AW'(1);
    end

    // [R1] word copy, two cycles per word
    unique case (s_r.xf)
      lbte_pkg::XF_IDLE: ;
      lbte_pkg::XF_RD:   s_nxt.xf = lbte_pkg::XF_WR;
      lbte_pkg::XF_WR: begin
        // [R4] source word into same index
        ram_we_b = s_r.a2b;
        ram_we_a = !s_r.a2b;
        if (finish) begin
          s_nxt.xf = lbte_pkg::XF_IDLE;
        end else begin
          s_nxt.idx = s_r.idx + AW'(1);
          s_nxt.xf  = lbte_pkg::XF_RD;
        end
      end
    endcase

    // new events are applied last so a same-cycle read never loses them
    if (module_irq_valid) begin
      s_nxt.mod_pend = 1'b1;
      s_nxt.mod_data = module_irq_data;
    end
    if (finish) begin
      // [R6] terminal count sources
      s_nxt.tc_a = 1'b1;
      s_nxt.tc_b = 1'b1;
      // [R5] buffers unassigned
      s_nxt.asg_a[lbte_pkg::ASSIGN_BIT] = 1'b0;
      s_nxt.asg_b[lbte_pkg::ASSIGN_BIT] = 1'b0;
    end
    // [R3] [R9] interrupt follows pending sources
    s_nxt.irq = s_nxt.tc_a || s_nxt.tc_b || s_nxt.mod_pend;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign pready              = s_r.pready;
  assign prdata              = s_r.prdata;
  assign pslverr             = s_r.pslverr;
  assign link_interrupt_line = s_r.irq;
  // [R10] trigger high-true, others low-true
  assign external_trigger_source = s_r.ev[0];
  assign run_halt_source         = s_r.ev[1];
  assign event_source_one        = s_r.ev[2];
  assign event_source_two        = s_r.ev[3];
  assign event_source_three      = s_r.ev[4];
  assign event_source_four       = s_r.ev[5];

  ////////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic diag_start;
  assign diag_start = done_acc && pwrite && (sel == lbte_pkg::REG_DIAG)
                      && pwdata[lbte_pkg::DIAG_XFER_BIT] && !busy;

  xfer_launch_a: assert property (diag_start |=> s_r.xf == lbte_pkg::XF_RD ##1 busy) // [R2]
    else $error("copy did not launch");
  copy_word_a: assert property (s_r.xf == lbte_pkg::XF_WR |-> // [R4]
      ram_addr == s_r.idx && $past(ram_addr) == s_r.idx
      && ram_we_b == s_r.a2b && ram_we_a == !s_r.a2b)
    else $error("copied word differs from source");
  done_irq_a: assert property (finish |=> link_interrupt_line && s_r.tc_a && s_r.tc_b) // [R3]
    else $error("no interrupt after copy");
  unassign_a: assert property (finish |=> // [R5]
      !s_r.asg_a[lbte_pkg::ASSIGN_BIT] && !s_r.asg_b[lbte_pkg::ASSIGN_BIT])
    else $error("buffer still assigned");
  tc_clear_a: assert property (done_acc && !pwrite && sel == lbte_pkg::REG_INT_SRC // [R7]
      && !finish |=> !s_r.tc_a && !s_r.tc_b)
    else $error("source bits not cleared by read");
  mod_read_a: assert property (done_acc && !pwrite && sel == lbte_pkg::REG_INT_DATA // [R8]
      && !module_irq_valid |=> !s_r.mod_pend)
    else $error("module interrupt not dropped");
  irq_level_a: assert property ( // [R9]
      link_interrupt_line == (s_r.tc_a || s_r.tc_b || s_r.mod_pend))
    else $error("interrupt line disagrees with sources");
  event_drive_a: assert property (done_acc && pwrite && sel == lbte_pkg::REG_EVENT // [R10]
      |=> {event_source_four, event_source_three, event_source_two, event_source_one,
           run_halt_source, external_trigger_source} == $past(pwdata[5:0]))
    else $error("event lines not driven from register");
  event_read_a: assert property (pready && !pwrite && sel == lbte_pkg::REG_EVENT // [R11]
      |-> prdata[5:0] == $past(lines) && prdata[31:6] == 26'h0)
    else $error("event readback wrong");

  copy_done_c:  cover property (finish ##[1:20] (done_acc && sel == lbte_pkg::REG_INT_SRC));
  mod_irq_c:    cover property (module_irq_valid ##[1:20]
      (done_acc && sel == lbte_pkg::REG_INT_DATA));
  ev_readback_c: cover property (done_acc && !pwrite && sel == lbte_pkg::REG_EVENT);

endmodule : lbte_link_buffer

`default_nettype wire

// file: tb/lbte_far_side.sv
`timescale 1ns/100ps
`default_nettype none
module lbte_far_side (
  // clock
  input  wire logic        clk,
  // drive from the block
  input  wire logic        trig_src,
  input  wire logic [4:0]  evt_src,
  // line states back to the block
  output logic             trig_line,
  output logic [4:0]       evt_line,
  // module interrupt
  output logic             irq_valid,
  output logic [15:0]      irq_data
);
  assign trig_line = trig_src;
  assign evt_line  = ~evt_src;

  initial begin
    irq_valid = 1'b0;
    irq_data  = 16'h0000;
  end

  task automatic send_irq(input logic [15:0] d);
    @(posedge clk);
    irq_valid <= 1'b1;
    irq_data  <= d;
    @(posedge clk);
    irq_valid <= 1'b0;
    // data means nothing without the strobe, so it must not linger
    irq_data  <= ~d;
  endtask : send_irq
endmodule : lbte_far_side
`default_nettype wire

// file: tb/link_buffer_transfer_events_bench.sv
`timescale 1ns/100ps
`default_nettype none
module link_buffer_transfer_events_bench;
  localparam int DEPTH = 16;
  typedef struct {logic [31:0] exp; logic chk; logic err;} lbte_note_s;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr;
  logic        irq_v, irq_line, trig_s, trig_l;
  logic [23:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] irq_d;
  wire logic [4:0] evt_s;
  logic [4:0]  evt_l;
  logic [15:0] mem [DEPTH];
  lbte_note_s  notes [$];
  lbte_note_s  cur;
  int          n_errors = 0;
  int          tests_run = 0;
  integer      seed = 32'h37D4;

  lbte_link_buffer #(.DEPTH(DEPTH)) DUT (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .module_irq_valid(irq_v), .module_irq_data(irq_d), .link_interrupt_line(irq_line),
    .external_trigger_source(trig_s), .run_halt_source(evt_s[0]),
    .event_source_one(evt_s[1]), .event_source_two(evt_s[2]),
    .event_source_three(evt_s[3]), .event_source_four(evt_s[4]),
    .trigger_line(trig_l), .run_halt_event_line(evt_l[0]), .event_line_one(evt_l[1]),
    .event_line_two(evt_l[2]), .event_line_three(evt_l[3]), .event_line_four(evt_l[4]));

  lbte_far_side far (.clk(mclk), .trig_src(trig_s), .evt_src(evt_s), .trig_line(trig_l),
    .evt_line(evt_l), .irq_valid(irq_v), .irq_data(irq_d));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] act, input logic [31:0] exp, input string m);
    tests_run++;
    if (act !== exp) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, act, exp);
    end
  endtask : chk

  // no cycle count assumed: the bound only stops a hang
  task automatic apb(input logic wr, input logic [23:0] a, input logic [31:0] d,
                     input logic c, input logic [31:0] e, input logic er);
    int n;
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    notes.push_back('{e, c, er});
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 200);
    chk(n < 200, 1, "no pready");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 1'b0, 32'h0, 1'b0);
  endtask : wr

  task automatic rd(input logic [23:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 1'b1, e, 1'b0);
  endtask : rd

  task automatic line_is(input logic e);
    repeat (2) @(posedge mclk);
    #1;
    chk({31'h0, irq_line}, {31'h0, e}, "interrupt line");
  endtask : line_is

  always @(posedge mclk) begin
    if (psel && penable && pready === 1'b1) begin
      chk(notes.size() > 0, 1, "unexpected answer");
      if (notes.size() > 0) begin
        cur = notes.pop_front();
        chk({31'h0, pslverr}, {31'h0, cur.err}, "pslverr");
        if (cur.chk) chk(prdata, cur.exp, "read data");
      end
    end
  end

  task automatic copy(input logic a2b);
    int          i;
    logic [23:0] src, dst;
    src = a2b ? lbte_pkg::BUF_A_DATA_OFF : lbte_pkg::BUF_B_DATA_OFF;
    dst = a2b ? lbte_pkg::BUF_B_DATA_OFF : lbte_pkg::BUF_A_DATA_OFF;
    wr(lbte_pkg::BUF_PTR_OFF, 0);
    for (i = 0; i < DEPTH; i++) begin
      mem[i] = 16'($random(seed));
      wr(src, {16'h0, mem[i]});
    end
    wr(lbte_pkg::BUF_PTR_OFF, 0);
    for (i = 0; i < DEPTH; i++) wr(dst, 0);
    wr(lbte_pkg::ASSIGN_A_OFF, 32'h20);
    wr(lbte_pkg::ASSIGN_B_OFF, a2b ? 32'h30 : 32'h20);
    wr(lbte_pkg::BUF_PTR_OFF, 0);
    wr(lbte_pkg::DIAG_CTRL_OFF, 32'h04);
    rd(lbte_pkg::DIAG_CTRL_OFF, 32'h04);
    // a window read during the copy must wait and then see the source word
    wr(lbte_pkg::BUF_PTR_OFF, 0);
    rd(src, {16'h0, mem[0]});
    i = 0;
    while (irq_line !== 1'b1 && i < 200) begin
      @(posedge mclk);
      i++;
    end
    chk({31'h0, irq_line}, 1, "copy end interrupt");
    rd(lbte_pkg::ASSIGN_A_OFF, 0);
    rd(lbte_pkg::ASSIGN_B_OFF, a2b ? 32'h10 : 32'h0);
    rd(lbte_pkg::DIAG_CTRL_OFF, 0);
    wr(lbte_pkg::BUF_PTR_OFF, 0);
    for (i = 0; i < DEPTH; i++) rd(dst, {16'h0, mem[i]});
  endtask : copy

  task automatic tally_and_finish;
    $display("mismatches %0d of %0d checks", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    static logic [5:0] tbl [7] = '{6'h3F, 6'h3C, 6'h3A, 6'h36, 6'h2E, 6'h1E, 6'h3E};
    logic [5:0]  v;
    logic [15:0] d;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 24'h000000;
    pwdata = 32'h0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    chk({26'h0, evt_s, trig_s}, 32'h3E, "event reset");
    rd(lbte_pkg::EVENT_BUS_OFF, 0);
    for (int i = 0; i < 11; i++) begin
      v = (i < 7) ? tbl[i] : 6'($random(seed));
      wr(lbte_pkg::EVENT_BUS_OFF, {26'h0, v});
      #1;
      chk({26'h0, evt_s, trig_s}, {26'h0, v}, "event drive");
      rd(lbte_pkg::EVENT_BUS_OFF, {26'h0, v ^ 6'h3E});
    end
    apb(1'b1, 24'hF06030, 32'h3F, 1'b0, 32'h0, 1'b1);
    apb(1'b0, 24'hF06030, 32'h0, 1'b0, 32'h0, 1'b1);
    rd(lbte_pkg::INT_SOURCE_OFF, 32'h10);
    copy(1'b1);
    d = 16'($random(seed));
    far.send_irq(d);
    rd(lbte_pkg::INT_SOURCE_OFF, 32'h60);
    line_is(1'b1);
    rd(lbte_pkg::INT_SOURCE_OFF, 32'h00);
    rd(lbte_pkg::INT_DATA_OFF, {16'h0, d});
    line_is(1'b0);
    rd(lbte_pkg::INT_SOURCE_OFF, 32'h10);
    copy(1'b0);
    rd(lbte_pkg::INT_SOURCE_OFF, 32'h70);
    line_is(1'b0);
    rd(lbte_pkg::INT_SOURCE_OFF, 32'h10);
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule : link_buffer_transfer_events_bench
`default_nettype wire
